// *** verification/jbp_chain_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbp_chain_model (
  // Test access port as the chain sees it.
  output logic      tck,
  output logic      tdo,
  input  wire logic tms,
  input  wire logic tdi
);
  logic [3:0] st = 4'h0;
  logic       bits[$];
  logic       lastIr;

  // Test clock state walk, codes 2 to 8 for data and 9 to f for instruction.
  function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
    case (s)
      4'h0: nxt = m ? 4'h0 : 4'h1;
      4'h1: nxt = m ? 4'h2 : 4'h1;
      4'h2: nxt = m ? 4'h9 : 4'h3;
      4'h3, 4'h4: nxt = m ? 4'h5 : 4'h4;
      4'h5: nxt = m ? 4'h8 : 4'h6;
      4'h6: nxt = m ? 4'h7 : 4'h6;
      4'h7: nxt = m ? 4'h8 : 4'h4;
      4'h9: nxt = m ? 4'h0 : 4'ha;
      4'ha, 4'hb: nxt = m ? 4'hc : 4'hb;
      4'hc: nxt = m ? 4'hf : 4'hd;
      4'hd: nxt = m ? 4'he : 4'hd;
      4'he: nxt = m ? 4'hf : 4'hb;
      default: nxt = m ? 4'h2 : 4'h1;
    endcase
  endfunction

  // Free-running test clock; the odd offset keeps it out of phase with clk_sys.
  initial begin
    tck = 1'b0;
    #7;
    forever #160 tck = ~tck;
  end

  // Every bit that enters the chain in a shift state is logged in time order.
  always @(posedge tck) begin
    if (st == 4'h4 || st == 4'hb) begin
      bits.push_back(tdi);
      lastIr = (st == 4'hb);
    end
    st <= nxt(st, tms);
  end

  // A one-bit path while shifting; otherwise the line toggles so it never looks held.
  initial begin
    tdo = 1'b0;
    forever @(negedge tck) tdo <= (st == 4'h4 || st == 4'hb) ? tdi : ~tdo;
  end
endmodule
`default_nettype wire

// *** verification/jbp_padder_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbp_padder_checker (
  // Clock, reset and bus.
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Test access port.
  input wire logic        tckIn,
  input wire logic        tdoIn,
  input wire logic        tmsOut,
  input wire logic        tdiOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Accepted address phases.
  wire accRd = hsel && htrans[1] && hready && !hwrite;
  wire accWr = hsel && htrans[1] && hready && hwrite;

  a_resp_okay: assert property (hresp == 1'b0) else $error("Bad response.");
  a_read_nowait: assert property (accRd |=> hreadyout) else $error("Read stalled.");
  a_data_stall: assert property (accWr && haddr[7:0] == 8'h20 |=> !hreadyout)
    else $error("Data push not stalled.");
  a_stall_ends: assert property ($fell(hreadyout) |-> ##[1:1000] hreadyout)
    else $error("Stall never ended.");
  a_unmapped_zero: assert property (accRd && haddr[7:0] == 8'h30 |=> hrdata == 32'h0)
    else $error("Unmapped read not zero.");
  a_status_clean: assert property (accRd && haddr[7:0] == 8'h04 |=> hrdata[31:5] == 27'h0)
    else $error("Status high bits set.");
  a_tms_on_fall: assert property (!$stable(tmsOut) |-> !$past(tckIn, 2))
    else $error("Mode line moved off a fall.");
  a_tdi_on_fall: assert property (!$stable(tdiOut) |-> !$past(tckIn, 2))
    else $error("Data line moved off a fall.");

  cover property (accWr && haddr[7:0] == 8'h20 ##1 !hreadyout [*2]);
  cover property (accRd && haddr[7:0] == 8'h30);
  cover property (!$stable(tdiOut));
endmodule
bind jbp_padder jbp_padder_checker i_chk (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tckIn, .tdoIn, .tmsOut, .tdiOut);
`default_nettype wire

// *** verification/jbp_padder_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbp_padder_test;
  logic clk_sys, arst_n, hsel, hwrite, tck, tdo;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic  hreadyout, hresp, tmsOut, tdiOut;
  int          fail_count = 0, n_checks = 0, cyc = 0;

  jbp_padder i_jbp_padder (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tckIn(tck), .tdoIn(tdo),
    .tmsOut(tmsOut), .tdiOut(tdiOut));
  jbp_chain_model i_jbp_chain_model (.tck(tck), .tdo(tdo), .tms(tmsOut), .tdi(tdiOut));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task tally_and_finish;
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The run is a few thousand cycles; a hang is cut off well beyond that.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single bus transfers; each phase is held until ready is seen high at an edge.
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Run one scan and compare the logged chain bits with lead pad, target, trail pad.
  task scan(input logic [1:0] k, input int len, input logic [95:0] d, input int nw,
            input int ld, input int tr);
    int   i, n;
    logic pad, b;
    logic [31:0] tx;
    i_jbp_chain_model.bits.delete();
    ahb(1'b1, 32'h1c, {14'h0, k, len[15:0]}, st);
    for (i = 0; i < nw; i++) ahb(1'b1, 32'h20, d[32*i +: 32], st);
    do ahb(1'b0, 32'h04, 32'h0, st); while (st[2:1] !== 2'b00);
    pad = (k == 2'h0);
    n = ld + len + tr;
    chk(i_jbp_chain_model.bits.size(), n);
    chk({31'h0, i_jbp_chain_model.lastIr}, {31'h0, pad});
    // The chain echoes each bit one fall late, so the capture ends on the next-to-last bit.
    for (i = 0; i < n; i++) begin
      b = (i < ld || i >= ld + len) ? pad : d[i - ld];
      chk({31'h0, i_jbp_chain_model.bits[i]}, {31'h0, b});
      if (i >= n - 33 && i < n - 1) tx[i - n + 33] = b;
    end
    if (n >= 33) begin
      ahb(1'b0, 32'h24, 32'h0, st);
      chk(st, tx);
    end
  endtask

  task run_ctl(input logic [31:0] v, input logic act);
    ahb(1'b1, 32'h00, v, st);
    do ahb(1'b0, 32'h04, 32'h0, st); while (st[0] !== act);
  endtask

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge clk_sys);
    chk({29'h0, hreadyout, tmsOut, tdiOut}, 32'h6);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, 32'h04, 32'h0, st);
    chk(st, 32'h0);
    ahb(1'b0, 32'h30, 32'h0, st);
    chk(st, 32'h0);
    // Third of four devices with five-bit instructions.
    ahb(1'b1, 32'h08, 32'd10, st);
    ahb(1'b1, 32'h0c, 32'd5, st);
    ahb(1'b1, 32'h10, 32'd2, st);
    ahb(1'b1, 32'h14, 32'd1, st);
    ahb(1'b1, 32'h18, 32'd31, st);
    ahb(1'b0, 32'h08, 32'h0, st);
    chk(st, 32'd10);
    run_ctl(32'h1, 1'b1);
    // Pads cleared mid-run must only take effect in the next run.
    for (int a = 8; a <= 24; a += 4) ahb(1'b1, a, 32'h0, st);
    scan(2'h0, 6, 96'h2d, 1, 10, 5);
    scan(2'h1, 70, 96'h3f_a5a5a5a5_12345678, 3, 2, 1);
    scan(2'h2, 8, 96'hc3, 1, 33, 1);
    run_ctl(32'h2, 1'b0);
    run_ctl(32'h1, 1'b1);
    scan(2'h0, 5, 96'h13, 1, 0, 0);
    scan(2'h2, 12, 96'h9b7, 1, 0, 0);
    scan(2'h1, 8, 96'h0, 0, 0, 0);
    chk({31'h0, st[3]}, 32'h1);
    run_ctl(32'h2, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** verilog/jbp_defines.vh ***
// Summary of operation
// - Every instruction scan shifts the set count of one-bits ahead of target bits.
// - Every instruction scan shifts the set count of one-bits after target bits.
// - Every data scan shifts the set count of zero-bits ahead of target bits.
// - Every data scan shifts the set count of zero-bits after target bits.
// - Configuration data scans add a separate zero-bit count for 32-bit alignment.
// - With all five counts zero, scans pass through unaltered.
// - All padding bits are generated here from the counts alone.
// - Padding assumes all-ones bypass instructions and one-bit bypass registers.
`ifndef JBP_DEFINES_VH
`define JBP_DEFINES_VH

// Register byte addresses.
`define JBP_ADDR_CTRL       8'h00
`define JBP_ADDR_STATUS     8'h04
`define JBP_ADDR_LEAD_IR    8'h08
`define JBP_ADDR_TRAIL_IR   8'h0c
`define JBP_ADDR_LEAD_DR    8'h10
`define JBP_ADDR_TRAIL_DR   8'h14
`define JBP_ADDR_ALIGN      8'h18
`define JBP_ADDR_SCAN_CMD   8'h1c
`define JBP_ADDR_SCAN_DATA  8'h20
`define JBP_ADDR_TDO_CAPT   8'h24

// Control register fields.
`define JBP_CTRL_START      0
`define JBP_CTRL_END        1

// Status register fields.
`define JBP_ST_RUN          0
`define JBP_ST_BUSY         1
`define JBP_ST_PEND         2
`define JBP_ST_UNDERRUN     3
`define JBP_ST_FULL         4

// Scan command fields: target length and scan kind.
`define JBP_CMD_LEN_LSB     0
`define JBP_CMD_LEN_MSB     15
`define JBP_CMD_KIND_LSB    16
`define JBP_CMD_KIND_MSB    17

// Scan kinds.
`define JBP_KIND_IR         2'h0
`define JBP_KIND_DR         2'h1
`define JBP_KIND_CFG        2'h2

// Pad fill values: bypass instruction is all ones, bypass data is zero.
`define JBP_IR_PAD_BIT      1'b1
`define JBP_DR_PAD_BIT      1'b0

// Falling edges with TMS high that force the test logic reset state.
`define JBP_TAP_RESET_EDGES 3'h5

`endif

// *** verilog/jbp_padder.v ***
`timescale 1ns/1ps
`default_nettype none
`include "jbp_defines.vh"

module jbp_padder #(
  parameter CW = 16
) (
  // System clock and reset.
  input  wire        clk_sys,
  input  wire        arst_n,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Test access port.
  input  wire        tckIn,
  input  wire        tdoIn,
  output reg         tmsOut,
  output reg         tdiOut
);

  // Scan controller states, named after the TAP state reached at the next rising edge.
  localparam S_OFF    = 3'h0;
  localparam S_RESET  = 3'h1;
  localparam S_IDLE   = 3'h2;
  localparam S_SELDR  = 3'h3;
  localparam S_SELIR  = 3'h4;
  localparam S_CAPT   = 3'h5;
  localparam S_SHIFT  = 3'h6;
  localparam S_EXIT   = 3'h7;

  // Pin synchronisers and edge detection.
  reg          tckS1, tckS2, tckS3;
  reg          tdoS1, tdoS2;
  wire         tckFall = tckS3 & ~tckS2;
  wire         tckRise = ~tckS3 & tckS2;

  // Software-visible configuration and working copies.
  reg [CW-1:0] leadIrCfg, trailIrCfg, leadDrCfg, trailDrCfg, alignCfg;
  reg [CW-1:0] leadIrRun, trailIrRun, leadDrRun, trailDrRun, alignRun;
  reg          runActive, runEndReq, runStartReq, underrun;

  // Pending scan command.
  reg          cmdPend;
  reg [1:0]    cmdKind;
  reg [15:0]   cmdLen;

  // Two-entry buffer for target data words.
  reg [31:0]   fifoMem [0:1];
  reg          wrPtr;
  reg          rdPtr;
  reg [1:0]    fifoCnt;
  wire         fifoFull  = (fifoCnt == 2'h2);
  wire         fifoValid = (fifoCnt != 2'h0);
  reg          pushValid;
  wire         pushReady = ~fifoFull;
  reg          popReady;

  // Scan engine.
  reg [2:0]    state;
  reg [2:0]    rstCnt;
  reg          isIr;
  reg [17:0]   pos, leadEnd, tgtEnd, total;
  reg          padBit;
  reg [31:0]   word;
  reg [4:0]    bitIdx;
  reg          sampleTdo;
  reg [31:0]   tdoCapt;

  // AHB data phase bookkeeping.
  reg          dpWrite, dpData;
  reg [7:0]    dpAddr;
  wire         addrAccept = hsel & htrans[1] & hready;

  // Two flip-flops on each pin before any logic looks at it.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tckS1 <= 1'b0;
      tckS2 <= 1'b0;
      tckS3 <= 1'b0;
      tdoS1 <= 1'b0;
      tdoS2 <= 1'b0;
    end else begin
      tckS1 <= tckIn;
      tckS2 <= tckS1;
      tckS3 <= tckS2;
      tdoS1 <= tdoIn;
      tdoS2 <= tdoS1;
    end
  end

  // Bus slave. Data writes take one wait state so a full buffer can hold the bus
  // off; that stall is the back-pressure that keeps a slow scan from losing words.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      dpWrite     <= 1'b0;
      dpData      <= 1'b0;
      dpAddr      <= 8'h00;
      pushValid   <= 1'b0;
      leadIrCfg   <= {CW{1'b0}};
      trailIrCfg  <= {CW{1'b0}};
      leadDrCfg   <= {CW{1'b0}};
      trailDrCfg  <= {CW{1'b0}};
      alignCfg    <= {CW{1'b0}};
      runStartReq <= 1'b0;
      runEndReq   <= 1'b0;
      cmdPend     <= 1'b0;
      cmdKind     <= `JBP_KIND_IR;
      cmdLen      <= 16'h0000;
    end else begin
      pushValid <= 1'b0;
      if (state == S_RESET)
        runStartReq <= 1'b0;
      if (!runActive)
        runEndReq <= 1'b0;
      if (state == S_IDLE && tckFall && cmdPend)
        cmdPend <= 1'b0;
      if (dpData) begin
        if (pushReady && !pushValid) begin
          pushValid <= 1'b1;
          hreadyout <= 1'b1;
          dpData    <= 1'b0;
        end
      end else if (dpWrite) begin
        dpWrite <= 1'b0;
        if (dpAddr == `JBP_ADDR_CTRL) begin
          if (hwdata[`JBP_CTRL_START] && !runActive)
            runStartReq <= 1'b1;
          if (hwdata[`JBP_CTRL_END] && runActive)
            runEndReq <= 1'b1;
        end else if (dpAddr == `JBP_ADDR_LEAD_IR) begin
          leadIrCfg <= hwdata[CW-1:0];
        end else if (dpAddr == `JBP_ADDR_TRAIL_IR) begin
          trailIrCfg <= hwdata[CW-1:0];
        end else if (dpAddr == `JBP_ADDR_LEAD_DR) begin
          leadDrCfg <= hwdata[CW-1:0];
        end else if (dpAddr == `JBP_ADDR_TRAIL_DR) begin
          trailDrCfg <= hwdata[CW-1:0];
        end else if (dpAddr == `JBP_ADDR_ALIGN) begin
          alignCfg <= hwdata[CW-1:0];
        end else if (dpAddr == `JBP_ADDR_SCAN_CMD) begin
          if (!cmdPend && runActive) begin
            cmdPend <= 1'b1;
            cmdKind <= hwdata[`JBP_CMD_KIND_MSB:`JBP_CMD_KIND_LSB];
            cmdLen  <= hwdata[`JBP_CMD_LEN_MSB:`JBP_CMD_LEN_LSB];
          end
        end
      end
      if (addrAccept) begin
        dpAddr <= haddr[7:0];
        if (hwrite && haddr[7:0] == `JBP_ADDR_SCAN_DATA) begin
          dpData    <= 1'b1;
          hreadyout <= 1'b0;
        end else if (hwrite) begin
          dpWrite <= 1'b1;
        end
        if (haddr[7:0] == `JBP_ADDR_STATUS)
          hrdata <= {27'h0, fifoFull, underrun, cmdPend, (state > S_IDLE), runActive};
        else if (haddr[7:0] == `JBP_ADDR_LEAD_IR)
          hrdata <= {{(32-CW){1'b0}}, leadIrCfg};
        else if (haddr[7:0] == `JBP_ADDR_TRAIL_IR)
          hrdata <= {{(32-CW){1'b0}}, trailIrCfg};
        else if (haddr[7:0] == `JBP_ADDR_LEAD_DR)
          hrdata <= {{(32-CW){1'b0}}, leadDrCfg};
        else if (haddr[7:0] == `JBP_ADDR_TRAIL_DR)
          hrdata <= {{(32-CW){1'b0}}, trailDrCfg};
        else if (haddr[7:0] == `JBP_ADDR_ALIGN)
          hrdata <= {{(32-CW){1'b0}}, alignCfg};
        else if (haddr[7:0] == `JBP_ADDR_SCAN_CMD)
          hrdata <= {14'h0, cmdKind, cmdLen};
        else if (haddr[7:0] == `JBP_ADDR_TDO_CAPT)
          hrdata <= tdoCapt;
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // Buffer storage and occupancy; push and pop may happen in the same cycle.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr   <= 1'b0;
      rdPtr   <= 1'b0;
      fifoCnt <= 2'h0;
    end else begin
      if (pushValid && pushReady) begin
        fifoMem[wrPtr] <= hwdata;
        wrPtr          <= ~wrPtr;
      end
      if (popReady && fifoValid)
        rdPtr <= ~rdPtr;
      fifoCnt <= fifoCnt + {1'b0, pushValid & pushReady} - {1'b0, popReady & fifoValid};
    end
  end

  // Pad bit for the scan in progress and the word source for target bits.
  always @* begin
    padBit   = isIr ? `JBP_IR_PAD_BIT : `JBP_DR_PAD_BIT;
    popReady = (state == S_SHIFT) && tckFall && (pos >= leadEnd) && (pos < tgtEnd) &&
               (bitIdx == 5'h00);
  end

  // Scan engine. Outputs change on TCK falling edges so the chain samples them stably
  // at the rising edge. A data underrun cannot stall a shift, since TCK runs freely,
  // so it shifts zeros and raises a sticky flag for software instead.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state      <= S_OFF;
      rstCnt     <= 3'h0;
      tmsOut     <= 1'b1;
      tdiOut     <= 1'b0;
      runActive  <= 1'b0;
      underrun   <= 1'b0;
      isIr       <= 1'b0;
      pos        <= 18'h0;
      leadEnd    <= 18'h0;
      tgtEnd     <= 18'h0;
      total      <= 18'h0;
      word       <= 32'h0000_0000;
      bitIdx     <= 5'h00;
      sampleTdo  <= 1'b0;
      tdoCapt    <= 32'h0000_0000;
      leadIrRun  <= {CW{1'b0}};
      trailIrRun <= {CW{1'b0}};
      leadDrRun  <= {CW{1'b0}};
      trailDrRun <= {CW{1'b0}};
      alignRun   <= {CW{1'b0}};
    end else begin
      if (tckRise && sampleTdo) begin
        tdoCapt   <= {tdoS2, tdoCapt[31:1]};
        sampleTdo <= 1'b0;
      end
      if (runStartReq && state == S_OFF) begin
        leadIrRun  <= leadIrCfg;
        trailIrRun <= trailIrCfg;
        leadDrRun  <= leadDrCfg;
        trailDrRun <= trailDrCfg;
        alignRun   <= alignCfg;
        runActive  <= 1'b1;
        underrun   <= 1'b0;
        rstCnt     <= 3'h0;
        state      <= S_RESET;
      end else if (tckFall) begin
        case (state)
          S_RESET: begin
            // Low on the last fall, so the TAP leaves reset for idle before any scan.
            tmsOut <= (rstCnt != `JBP_TAP_RESET_EDGES);
            rstCnt <= rstCnt + 3'h1;
            if (rstCnt == `JBP_TAP_RESET_EDGES)
              state <= S_IDLE;
          end
          S_IDLE: begin
            tmsOut <= 1'b0;
            if (cmdPend) begin
              tmsOut <= 1'b1;
              state  <= S_SELDR;
              isIr   <= (cmdKind == `JBP_KIND_IR);
              pos    <= 18'h0;
              bitIdx <= 5'h00;
              if (cmdKind == `JBP_KIND_IR) begin
                leadEnd <= {2'h0, leadIrRun};
                tgtEnd  <= {2'h0, leadIrRun} + {2'h0, cmdLen};
                total   <= {2'h0, leadIrRun} + {2'h0, cmdLen} + {2'h0, trailIrRun};
              end else if (cmdKind == `JBP_KIND_CFG) begin
                leadEnd <= {2'h0, leadDrRun} + {2'h0, alignRun};
                tgtEnd  <= {2'h0, leadDrRun} + {2'h0, alignRun} + {2'h0, cmdLen};
                total   <= {2'h0, leadDrRun} + {2'h0, alignRun} + {2'h0, cmdLen} +
                           {2'h0, trailDrRun};
              end else begin
                leadEnd <= {2'h0, leadDrRun};
                tgtEnd  <= {2'h0, leadDrRun} + {2'h0, cmdLen};
                total   <= {2'h0, leadDrRun} + {2'h0, cmdLen} + {2'h0, trailDrRun};
              end
            end else if (runEndReq) begin
              runActive <= 1'b0;
              state     <= S_OFF;
            end
          end
          S_SELDR: begin
            tmsOut <= isIr;
            state  <= isIr ? S_SELIR : S_CAPT;
          end
          S_SELIR: begin
            tmsOut <= 1'b0;
            state  <= S_CAPT;
          end
          S_CAPT: begin
            tmsOut <= (total == 18'h0); // An empty scan goes from Capture straight to Exit1.
            state  <= (total == 18'h0) ? S_EXIT : S_SHIFT;
          end
          S_SHIFT: begin
            // One unbroken stream of lead pad, target and trail pad.
            sampleTdo <= 1'b1;
            pos       <= pos + 18'h1;
            if (pos < leadEnd || pos >= tgtEnd) begin
              tdiOut <= padBit;
            end else if (bitIdx == 5'h00) begin
              tdiOut <= fifoValid ? fifoMem[rdPtr][0] : 1'b0;
              word   <= fifoValid ? {1'b0, fifoMem[rdPtr][31:1]} : 32'h0000_0000;
              bitIdx <= 5'h01;
              if (!fifoValid)
                underrun <= 1'b1;
            end else begin
              tdiOut <= word[0];
              word   <= {1'b0, word[31:1]};
              bitIdx <= bitIdx + 5'h01;
            end
            if (pos + 18'h1 == total) begin
              tmsOut <= 1'b1;
              state  <= S_EXIT;
            end else begin
              tmsOut <= 1'b0;
            end
          end
          S_EXIT: begin
            // Exit1 then Update; the S_IDLE branch walks Update to idle, or to Select-DR when a command is pending.
            tmsOut <= 1'b1;
            state  <= S_IDLE;
          end
          default: begin
            tmsOut <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire
